/* File: core/sms_pkg.sv */
// Shared constants and types of the start-up mode selector
package sms_pkg;

    // ------------------------------------------------------------------
    // Three-level pin decode and start-up modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SMS_LVL_LOW, SMS_LVL_MID, SMS_LVL_HIGH} sms_level_e;
    typedef enum logic [1:0] {SMS_MODE_EEPROM_I2C, SMS_MODE_EEPROM_SPI, SMS_MODE_ROM_I2C} sms_mode_e;
    typedef enum logic {SMS_PH_POR, SMS_PH_RUN} sms_phase_e;

    // ------------------------------------------------------------------
    // I2C target addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] SMS_I2C_ADDR_BASE = 5'h19;
    localparam logic [6:0] SMS_I2C_ADDR_ROM  = 7'h64;
    localparam logic [1:0] SMS_LSB_LOW       = 2'h0;
    localparam logic [1:0] SMS_LSB_MID       = 2'h1;
    localparam logic [1:0] SMS_LSB_HIGH      = 2'h2;

    // ------------------------------------------------------------------
    // Bit positions in the synchronised pin vector
    // ------------------------------------------------------------------
    localparam int SMS_SYNC_W     = 13;
    localparam int SMS_B_PDN      = 0;
    localparam int SMS_B_STRAP_LO = 1;
    localparam int SMS_B_STRAP_HI = 2;
    localparam int SMS_B_ADDR_LO  = 3;
    localparam int SMS_B_ADDR_HI  = 4;
    localparam int SMS_B_STA_LO   = 5;
    localparam int SMS_B_STA_HI   = 6;
    localparam int SMS_B_STB_LO   = 7;
    localparam int SMS_B_STB_HI   = 8;
    localparam int SMS_B_SYNCN    = 9;
    localparam int SMS_B_FUP      = 10;
    localparam int SMS_B_SDA      = 11;
    localparam int SMS_B_SCL      = 12;

    // ------------------------------------------------------------------
    // Selector state and its reset value
    // ------------------------------------------------------------------
    typedef struct packed {
        sms_phase_e phase;
        sms_mode_e  mode;
        logic [2:0] page;
        logic [6:0] i2c_addr;
        logic       ser_clk;
        logic       ser_din;
        logic       cs_n;
        logic       sync_req;
        logic       f_up;
        logic       f_dn;
        logic       sdo;
        logic       sdo_oe;
        logic       st_a;
        logic       st_a_oe;
        logic       st_b;
        logic       st_b_oe;
    } sms_state_s;

    localparam sms_state_s SMS_STATE_RST = '{
        phase: SMS_PH_POR, mode: SMS_MODE_EEPROM_I2C, page: 3'h0,
        i2c_addr: {SMS_I2C_ADDR_BASE, SMS_LSB_LOW}, ser_clk: 1'b0, ser_din: 1'b0,
        cs_n: 1'b1, sync_req: 1'b0, f_up: 1'b0, f_dn: 1'b0, sdo: 1'b0, sdo_oe: 1'b0,
        st_a: 1'b0, st_a_oe: 1'b0, st_b: 1'b0, st_b_oe: 1'b0};

endpackage : sms_pkg

/* File: core/sms_sync_if.sv */
// Carrier between the selector and its pin sampler
`timescale 1ns/1ns
interface sms_sync_if #(parameter int W = 13);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    logic [W-1:0] rise;

    modport sampler (input raw, output sync, output rise);
    modport core    (output raw, input sync, input rise);
endinterface : sms_sync_if

/* File: core/sms_pin_sampler.sv */
// Two-flop synchroniser with rising-edge detect for the pin inputs
`timescale 1ns/1ns
module sms_pin_sampler #(
    parameter int W = 13
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Pins in, synchronised levels and edges out
    sms_sync_if.sampler p
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } sms_samp_s;

    sms_samp_s r;
    sms_samp_s next_r;

    // ------------------------------------------------------------------
    // Stage one is read by stage two only
    // ------------------------------------------------------------------
    always_comb
    begin
        next_r    = r;
        next_r.s1 = p.raw;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign p.sync = r.s2;
    assign p.rise = r.s2 & ~r.s3;
endmodule : sms_pin_sampler

/* File: core/sms_startup_mode_select.sv */
// Start-up mode selector: strap sampling and shared pin assignment
// Function
// - Three-level strap picks one of three modes
// - Strap low: EEPROM load, I2C at 11001xx
// - Address pin sets I2C LSBs 00/01/10
// - Strap mid, both status pins mid: EEPROM load with SPI access
// - SPI mode remaps data, clock, select, out
// - EEPROM modes: sync pin is active-low input
// - Strap high: ROM page from three pins
// - ROM mode: I2C at fixed address 0x64
// - ROM mode: step pins only when enabled
// - Step pins move oscillator up or down
// - Steps need oscillator mode and pin control
// - Straps sampled only at power-on reset
// - Strap and status pins sampled at release
// - Status A drives push-pull after start-up; B too unless it is the step-down input
// - One register map over I2C or SPI
`timescale 1ns/1ns
module sms_startup_mode_select
    import sms_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Three-level pin comparators: [0] above low threshold, [1] above high
    input  wire logic [1:0] startup_mode_strap_cmp,
    input  wire logic [1:0] addr_select_or_chip_select_cmp,
    input  wire logic [1:0] status_out_a_cmp,
    input  wire logic [1:0] freq_down_or_status_b_cmp,
    // Two-level pin inputs
    input  wire logic       power_down_n,
    input  wire logic       output_sync_n,
    input  wire logic       freq_up_or_serial_out_in,
    input  wire logic       serial_data_in_pin,
    input  wire logic       serial_clock_pin,
    // Pin drivers
    output logic            freq_up_or_serial_out_o,
    output logic            freq_up_or_serial_out_oe,
    output logic            status_out_a_o,
    output logic            status_out_a_oe,
    output logic            freq_down_or_status_b_o,
    output logic            freq_down_or_status_b_oe,
    // Configuration from the register file
    input  wire logic       dco_mode_en,
    input  wire logic       gpio_ctrl_en,
    input  wire logic       rom_gpio_en,
    input  wire logic       status_b_as_freq_down,
    input  wire logic       status_a_src,
    input  wire logic       status_b_src,
    // Serial engine side
    input  wire logic       spi_sdo,
    input  wire logic       spi_sdo_en,
    output logic            ser_clk,
    output logic            ser_data_in,
    output logic            spi_cs_n,
    // Start-up results
    output sms_mode_e       startup_mode,
    output logic            startup_done,
    output logic            load_from_eeprom,
    output logic            load_from_rom,
    output logic [2:0]      rom_page,
    output logic            i2c_enable,
    output logic            spi_enable,
    output logic [6:0]      i2c_address,
    // Oscillator control
    output logic            output_sync_req,
    output logic            freq_step_up,
    output logic            freq_step_down
);
    // ------------------------------------------------------------------
    // Three-level decode; a contradictory comparator pair reads as mid
    // ------------------------------------------------------------------
    function automatic sms_level_e sms_decode(input logic [1:0] cmp);
        sms_level_e lvl;
        case (cmp)
            2'h0:    lvl = SMS_LVL_LOW;
            2'h3:    lvl = SMS_LVL_HIGH;
            default: lvl = SMS_LVL_MID;
        endcase
        return lvl;
    endfunction : sms_decode

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    sms_sync_if #(.W(SMS_SYNC_W)) pins ();

    assign pins.raw[SMS_B_PDN]                     = power_down_n;
    assign pins.raw[SMS_B_STRAP_HI:SMS_B_STRAP_LO] = startup_mode_strap_cmp;
    assign pins.raw[SMS_B_ADDR_HI:SMS_B_ADDR_LO]   = addr_select_or_chip_select_cmp;
    assign pins.raw[SMS_B_STA_HI:SMS_B_STA_LO]     = status_out_a_cmp;
    assign pins.raw[SMS_B_STB_HI:SMS_B_STB_LO]     = freq_down_or_status_b_cmp;
    assign pins.raw[SMS_B_SYNCN]                   = output_sync_n;
    assign pins.raw[SMS_B_FUP]                     = freq_up_or_serial_out_in;
    assign pins.raw[SMS_B_SDA]                     = serial_data_in_pin;
    assign pins.raw[SMS_B_SCL]                     = serial_clock_pin;

    sms_pin_sampler #(.W(SMS_SYNC_W)) u_sampler (
        .clk    (clk),
        .arst_n (arst_n),
        .p      (pins.sampler)
    );

    // ------------------------------------------------------------------
    // Selector state
    // ------------------------------------------------------------------
    sms_state_s r;
    sms_state_s next_r;

    always_comb
    begin
        sms_level_e strap_lvl;
        sms_level_e addr_lvl;
        sms_level_e sta_lvl;
        sms_level_e stb_lvl;
        sms_mode_e  new_mode;
        logic [1:0] addr_lsb;
        logic       steps_ok;
        logic       b_is_freq_step_down;

        strap_lvl = sms_decode(pins.sync[SMS_B_STRAP_HI:SMS_B_STRAP_LO]);
        addr_lvl  = sms_decode(pins.sync[SMS_B_ADDR_HI:SMS_B_ADDR_LO]);
        sta_lvl   = sms_decode(pins.sync[SMS_B_STA_HI:SMS_B_STA_LO]);
        stb_lvl   = sms_decode(pins.sync[SMS_B_STB_HI:SMS_B_STB_LO]);
        new_mode  = SMS_MODE_EEPROM_I2C;
        addr_lsb  = SMS_LSB_LOW;
        steps_ok  = 1'b0;
        b_is_freq_step_down = 1'b0;
        next_r    = r;
        next_r.f_up = 1'b0;
        next_r.f_dn = 1'b0;

        case (strap_lvl)
            SMS_LVL_LOW:  new_mode = SMS_MODE_EEPROM_I2C;
            SMS_LVL_HIGH: new_mode = SMS_MODE_ROM_I2C;
            SMS_LVL_MID:
            begin
                // A status pin pulled away from mid spoils the SPI pick
                if (sta_lvl == SMS_LVL_MID && stb_lvl == SMS_LVL_MID)
                    new_mode = SMS_MODE_EEPROM_SPI;
                else
                    new_mode = SMS_MODE_EEPROM_I2C;
            end
            default:      new_mode = SMS_MODE_EEPROM_I2C;
        endcase

        case (addr_lvl)
            SMS_LVL_LOW:  addr_lsb = SMS_LSB_LOW;
            SMS_LVL_MID:  addr_lsb = SMS_LSB_MID;
            SMS_LVL_HIGH: addr_lsb = SMS_LSB_HIGH;
            default:      addr_lsb = SMS_LSB_LOW;
        endcase

        steps_ok  = dco_mode_en && gpio_ctrl_en
                    && (r.mode == SMS_MODE_EEPROM_I2C
                        || (r.mode == SMS_MODE_ROM_I2C && rom_gpio_en));
        b_is_freq_step_down = steps_ok && status_b_as_freq_down;

        case (r.phase)
            SMS_PH_POR:
            begin
                // Status pins float so the strap bias can be read
                next_r.st_a_oe  = 1'b0;
                next_r.st_b_oe  = 1'b0;
                next_r.sdo_oe   = 1'b0;
                next_r.cs_n     = 1'b1;
                next_r.sync_req = 1'b0;
                if (pins.rise[SMS_B_PDN])
                begin
                    // Straps are taken only here, never while running
                    next_r.phase = SMS_PH_RUN;
                    next_r.mode  = new_mode;
                    next_r.page  = {pins.sync[SMS_B_FUP], pins.sync[SMS_B_ADDR_HI],
                                    pins.sync[SMS_B_SYNCN]};
                    if (new_mode == SMS_MODE_ROM_I2C)
                        next_r.i2c_addr = SMS_I2C_ADDR_ROM;
                    else
                        next_r.i2c_addr = {SMS_I2C_ADDR_BASE, addr_lsb};
                end
            end
            SMS_PH_RUN:
            begin
                if (!pins.sync[SMS_B_PDN])
                begin
                    // Latched mode survives power-down until the next release
                    next_r.phase = SMS_PH_POR;
                end
                else
                begin
                    next_r.ser_clk  = pins.sync[SMS_B_SCL];
                    next_r.ser_din  = pins.sync[SMS_B_SDA];
                    next_r.cs_n     = (r.mode == SMS_MODE_EEPROM_SPI) ? pins.sync[SMS_B_ADDR_HI] : 1'b1;
                    next_r.sdo      = spi_sdo;
                    next_r.sdo_oe   = (r.mode == SMS_MODE_EEPROM_SPI) && spi_sdo_en;
                    next_r.sync_req = (r.mode != SMS_MODE_ROM_I2C) && !pins.sync[SMS_B_SYNCN];
                    next_r.f_up     = steps_ok && pins.rise[SMS_B_FUP];
                    next_r.f_dn     = b_is_freq_step_down && pins.rise[SMS_B_STB_HI];
                    next_r.st_a     = status_a_src;
                    next_r.st_a_oe  = 1'b1;
                    next_r.st_b     = status_b_src;
                    next_r.st_b_oe  = !b_is_freq_step_down;
                end
            end
            default: next_r = SMS_STATE_RST;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r <= SMS_STATE_RST;
        else
            r <= next_r;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign freq_up_or_serial_out_o  = r.sdo;
    assign freq_up_or_serial_out_oe = r.sdo_oe;
    assign status_out_a_o           = r.st_a;
    assign status_out_a_oe          = r.st_a_oe;
    assign freq_down_or_status_b_o  = r.st_b;
    assign freq_down_or_status_b_oe = r.st_b_oe;
    assign ser_clk                  = r.ser_clk;
    assign ser_data_in              = r.ser_din;
    assign spi_cs_n                 = r.cs_n;
    assign startup_mode             = r.mode;
    assign startup_done             = (r.phase == SMS_PH_RUN);
    assign load_from_eeprom         = startup_done && (r.mode != SMS_MODE_ROM_I2C);
    assign load_from_rom            = startup_done && (r.mode == SMS_MODE_ROM_I2C);
    assign rom_page                 = r.page;
    // After start-up exactly one engine reaches the shared register map; none before
    assign i2c_enable               = startup_done && (r.mode != SMS_MODE_EEPROM_SPI);
    assign spi_enable               = startup_done && (r.mode == SMS_MODE_EEPROM_SPI);
    assign i2c_address              = r.i2c_addr;
    assign output_sync_req          = r.sync_req;
    assign freq_step_up             = r.f_up;
    assign freq_step_down           = r.f_dn;
endmodule : sms_startup_mode_select

/* File: verif/sms_host_model.sv */
// Host side of the pins: three-level bias and shared pin wiring
`timescale 1ns/1ns
module sms_host_model
    import sms_pkg::*;
(
    // Bias levels set by the host
    input  wire logic [1:0]  strap_lvl,
    input  wire logic [1:0]  addr_lvl,
    input  wire logic [1:0]  sta_lvl,
    input  wire logic [1:0]  stb_lvl,
    input  wire logic        fup_host,
    // Device pin drivers
    input  wire logic        sta_o,
    input  wire logic        sta_oe,
    input  wire logic        stb_o,
    input  wire logic        stb_oe,
    input  wire logic        fup_o,
    input  wire logic        fup_oe,
    // Levels seen by the device
    output logic [1:0]       strap_cmp,
    output logic [1:0]       addr_cmp,
    output logic [1:0]       sta_cmp,
    output logic [1:0]       stb_cmp,
    output logic             fup_pin
);
    // Float sits between the two thresholds
    function automatic logic [1:0] to_cmp(input logic [1:0] l);
        return (l == SMS_LVL_HIGH) ? 2'h3 : (l == SMS_LVL_MID) ? 2'h1 : 2'h0;
    endfunction : to_cmp

    // Strap and address pins follow whatever bias level the host sets
    assign strap_cmp = to_cmp(strap_lvl);
    assign addr_cmp  = to_cmp(addr_lvl);
    // Push-pull status drive overrides the resistor bias
    assign sta_cmp   = sta_oe ? {2{sta_o}} : to_cmp(sta_lvl);
    assign stb_cmp   = stb_oe ? {2{stb_o}} : to_cmp(stb_lvl);
    assign fup_pin   = fup_oe ? fup_o : fup_host;
endmodule : sms_host_model

/* File: verif/sms_startup_mode_select_chk.sv */
// Concurrent checks on the start-up mode selector ports
`timescale 1ns/1ns
module sms_startup_mode_select_chk
    import sms_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Observed ports
    input  wire logic        freq_up_or_serial_out_in,
    input  wire logic        dco_mode_en,
    input  wire logic        gpio_ctrl_en,
    input  wire logic        status_out_a_oe,
    input  wire logic        spi_cs_n,
    input  sms_mode_e        startup_mode,
    input  wire logic        startup_done,
    input  wire logic        load_from_eeprom,
    input  wire logic        load_from_rom,
    input  wire logic [2:0]  rom_page,
    input  wire logic        i2c_enable,
    input  wire logic        spi_enable,
    input  wire logic [6:0]  i2c_address,
    input  wire logic        output_sync_req,
    input  wire logic        freq_step_up
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_idle_before_start: assert property (!startup_done && !$past(startup_done) |-> !status_out_a_oe)
        else $error("status driven before start-up");
    a_eeprom_i2c_mode: assert property (startup_done && startup_mode == SMS_MODE_EEPROM_I2C |-> i2c_enable
        && !spi_enable && load_from_eeprom && i2c_address[6:2] == SMS_I2C_ADDR_BASE && i2c_address[1:0] != 2'h3)
        else $error("eeprom i2c outputs wrong");
    a_spi_mode_out: assert property (startup_done && startup_mode == SMS_MODE_EEPROM_SPI |-> spi_enable
        && !i2c_enable && load_from_eeprom && !load_from_rom)
        else $error("spi mode outputs wrong");
    a_rom_fixed_addr: assert property (startup_done && startup_mode == SMS_MODE_ROM_I2C |-> load_from_rom
        && !load_from_eeprom && i2c_enable && i2c_address == SMS_I2C_ADDR_ROM)
        else $error("rom mode outputs wrong");
    a_cs_idle_high: assert property (startup_mode != SMS_MODE_EEPROM_SPI
        && $past(startup_mode) != SMS_MODE_EEPROM_SPI |-> spi_cs_n)
        else $error("chip select active outside spi");
    a_latch_hold: assert property (startup_done && $past(startup_done) |-> $stable(startup_mode)
        && $stable(i2c_address) && $stable(rom_page))
        else $error("latched start-up value moved");
    a_sync_not_rom: assert property (output_sync_req |-> startup_mode != SMS_MODE_ROM_I2C)
        else $error("sync request in rom mode");
    a_step_gated: assert property (freq_step_up |-> dco_mode_en && gpio_ctrl_en
        && startup_mode != SMS_MODE_EEPROM_SPI ##1 !freq_step_up)
        else $error("step pulse not allowed or too long");
    a_step_follows: assert property ($rose(freq_up_or_serial_out_in) && dco_mode_en && gpio_ctrl_en
        && startup_done && startup_mode == SMS_MODE_EEPROM_I2C |-> ##[1:6] (freq_step_up || !startup_done))
        else $error("step pulse missing");
    a_status_drive: assert property (startup_done && $past(startup_done) |-> status_out_a_oe)
        else $error("status pin not driven");

    c_spi_start: cover property (startup_done && startup_mode == SMS_MODE_EEPROM_SPI);
    c_rom_start: cover property (startup_done && startup_mode == SMS_MODE_ROM_I2C);
    c_step_up: cover property (freq_step_up);
endmodule : sms_startup_mode_select_chk

bind sms_startup_mode_select sms_startup_mode_select_chk u_chk (.clk, .arst_n, .freq_up_or_serial_out_in,
    .dco_mode_en, .gpio_ctrl_en, .status_out_a_oe, .spi_cs_n, .startup_mode, .startup_done, .load_from_eeprom,
    .load_from_rom, .rom_page, .i2c_enable, .spi_enable, .i2c_address, .output_sync_req, .freq_step_up);

/* File: verif/sms_startup_mode_select_bench.sv */
// Self-checking bench of the start-up mode selector
`timescale 1ns/1ns
module sms_startup_mode_select_bench
    import sms_pkg::*;
;
    logic clk, arst_n, power_down_n, output_sync_n, fup_host, sdi_pin, sck_pin, fup_pin, fup_o, fup_oe;
    logic dco_mode_en, gpio_ctrl_en, rom_gpio_en, stb_fdn, sta_src, stb_src, spi_sdo, spi_sdo_en;
    logic sta_o, sta_oe, stb_o, stb_oe, ser_clk, ser_din, spi_cs_n, startup_done, ld_ee, ld_rom;
    logic i2c_en, spi_en, sync_req, step_up, step_dn;
    logic [1:0] strap_cmp, addr_cmp, sta_cmp, stb_cmp;
    logic [2:0] rom_page, pg;
    logic [6:0] i2c_address;
    sms_mode_e  startup_mode;
    logic [1:0] strap_lvl, addr_lvl, sta_lvl, stb_lvl;
    int         err_count, num_checks, n_up, n_dn;

    sms_startup_mode_select dut (.clk, .arst_n, .startup_mode_strap_cmp(strap_cmp),
        .addr_select_or_chip_select_cmp(addr_cmp), .status_out_a_cmp(sta_cmp), .freq_down_or_status_b_cmp(stb_cmp),
        .power_down_n, .output_sync_n, .freq_up_or_serial_out_in(fup_pin), .serial_data_in_pin(sdi_pin),
        .serial_clock_pin(sck_pin), .freq_up_or_serial_out_o(fup_o), .freq_up_or_serial_out_oe(fup_oe),
        .status_out_a_o(sta_o), .status_out_a_oe(sta_oe), .freq_down_or_status_b_o(stb_o),
        .freq_down_or_status_b_oe(stb_oe), .dco_mode_en, .gpio_ctrl_en, .rom_gpio_en,
        .status_b_as_freq_down(stb_fdn), .status_a_src(sta_src), .status_b_src(stb_src), .spi_sdo, .spi_sdo_en,
        .ser_clk, .ser_data_in(ser_din), .spi_cs_n, .startup_mode, .startup_done, .load_from_eeprom(ld_ee),
        .load_from_rom(ld_rom), .rom_page, .i2c_enable(i2c_en), .spi_enable(spi_en), .i2c_address,
        .output_sync_req(sync_req), .freq_step_up(step_up), .freq_step_down(step_dn));

    sms_host_model host (.strap_lvl, .addr_lvl, .sta_lvl, .stb_lvl, .fup_host, .sta_o, .sta_oe, .stb_o, .stb_oe,
        .fup_o, .fup_oe, .strap_cmp, .addr_cmp, .sta_cmp, .stb_cmp, .fup_pin);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk_bit

    task automatic chk_vec(input logic [6:0] got, input logic [6:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk_vec

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // Power-down low, pins biased, release and wait for start-up
    task automatic start(input sms_level_e s, a, ta, tb, input logic sn, fu);
        int i;
        power_down_n = 1'b0;
        {strap_lvl, addr_lvl, sta_lvl, stb_lvl} = {s, a, ta, tb};
        {output_sync_n, fup_host} = {sn, fu};
        tick(4);
        power_down_n = 1'b1;
        i = 0;
        while (startup_done !== 1'b1 && i < 20)
        begin
            tick(1);
            i++;
        end
        if (i == 20)
        begin
            err_count++;
            $display("[ERR] %0t start-up timeout", $time);
            end_sim();
        end
        tick(1);
    endtask : start

    // Raise one step pin and count pulses on both step outputs
    task automatic step(input logic up, input int exp_up, input int exp_dn);
        {n_up, n_dn} = '0;
        if (up)
            fup_host = 1'b1;
        else
            stb_lvl = SMS_LVL_HIGH;
        repeat (8)
        begin
            tick(1);
            n_up += int'(step_up === 1'b1);
            n_dn += int'(step_dn === 1'b1);
        end
        fup_host = 1'b0;
        stb_lvl = SMS_LVL_LOW;
        tick(3);
        chk_vec(7'(n_up), 7'(exp_up), "up step count");
        chk_vec(7'(n_dn), 7'(exp_dn), "down step count");
    endtask : step

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        {arst_n, power_down_n, fup_host, sdi_pin, sck_pin, dco_mode_en, gpio_ctrl_en} = '0;
        {rom_gpio_en, stb_fdn, sta_src, stb_src, spi_sdo, spi_sdo_en, err_count, num_checks} = '0;
        output_sync_n = 1'b1;
        {strap_lvl, addr_lvl, sta_lvl, stb_lvl} = {4{SMS_LVL_LOW}};
        tick(2);
        arst_n = 1'b1;
        tick(3);
        chk_vec(i2c_address, SMS_I2C_ADDR_ROM, "reset address");
        chk_bit(startup_done, 1'b0, "done before release");
        chk_bit(sta_oe, 1'b0, "status driven early");
        $display("test reset done");
        for (int k = 0; k < 3; k++)
        begin
            start(SMS_LVL_LOW, sms_level_e'(k), SMS_LVL_LOW, SMS_LVL_LOW, 1'b1, 1'b0);
            chk_vec(7'(startup_mode), 7'(SMS_MODE_EEPROM_I2C), "mode");
            chk_vec(i2c_address, {SMS_I2C_ADDR_BASE, 2'(k)}, "i2c address");
            chk_bit(ld_ee & i2c_en & ~spi_en, 1'b1, "eeprom i2c enables");
        end
        strap_lvl = SMS_LVL_HIGH;
        {sta_src, stb_src} = 2'h3;
        output_sync_n = 1'b0;
        tick(5);
        chk_vec(7'(startup_mode), 7'(SMS_MODE_EEPROM_I2C), "mode moved");
        chk_bit(sync_req, 1'b1, "sync request");
        chk_bit(sta_oe & sta_o, 1'b1, "status a drive");
        chk_bit(stb_oe & stb_o, 1'b1, "status b drive");
        output_sync_n = 1'b1;
        tick(5);
        chk_bit(sync_req, 1'b0, "sync release");
        {dco_mode_en, gpio_ctrl_en, stb_fdn} = 3'h7;
        tick(2);
        step(1'b1, 1, 0);
        step(1'b0, 0, 1);
        dco_mode_en = 1'b0;
        tick(2);
        step(1'b1, 0, 0);
        dco_mode_en = 1'b1;
        $display("test eeprom i2c done");
        start(SMS_LVL_MID, SMS_LVL_HIGH, SMS_LVL_MID, SMS_LVL_MID, 1'b1, 1'b0);
        chk_vec(7'(startup_mode), 7'(SMS_MODE_EEPROM_SPI), "spi mode");
        chk_bit(spi_en & ~i2c_en & ld_ee, 1'b1, "spi enables");
        addr_lvl = SMS_LVL_LOW;
        {sck_pin, sdi_pin, spi_sdo, spi_sdo_en} = 4'hF;
        tick(4);
        chk_vec(7'({spi_cs_n, ser_clk, ser_din, fup_oe, fup_o}), 7'h0F, "spi pin map");
        {sck_pin, sdi_pin, spi_sdo_en} = 3'h0;
        tick(2);
        step(1'b1, 0, 0);
        start(SMS_LVL_MID, SMS_LVL_LOW, SMS_LVL_LOW, SMS_LVL_MID, 1'b1, 1'b0);
        chk_vec(7'(startup_mode), 7'(SMS_MODE_EEPROM_I2C), "mid strap fallback");
        $display("test spi done");
        for (int k = 0; k < 2; k++)
        begin
            pg = k ? 3'h2 : 3'h5;
            start(SMS_LVL_HIGH, pg[1] ? SMS_LVL_HIGH : SMS_LVL_LOW, SMS_LVL_LOW, SMS_LVL_LOW, pg[0], pg[2]);
            fup_host = 1'b0;
            chk_vec(7'(startup_mode), 7'(SMS_MODE_ROM_I2C), "rom mode");
            chk_vec(7'(rom_page), 7'(pg), "rom page");
            chk_vec(i2c_address, SMS_I2C_ADDR_ROM, "rom address");
            chk_bit(ld_rom, 1'b1, "rom load");
        end
        tick(3);
        step(1'b1, 0, 0);
        rom_gpio_en = 1'b1;
        tick(2);
        step(1'b1, 1, 0);
        step(1'b0, 0, 1);
        $display("test rom done");
        end_sim();
    end
endmodule : sms_startup_mode_select_bench
